// >>> tx_source_defs.svh
// Register offsets, field positions, reset values and AXI response codes for the transmit source mux
`ifndef TX_SOURCE_DEFS_SVH
`define TX_SOURCE_DEFS_SVH

// ==========================================================
// Register byte offsets
`define TSS_OFF_TXSEL 8'h00
`define TSS_OFF_TESTSEL 8'h04
`define TSS_OFF_DRVCTL 8'h08
`define TSS_OFF_STATUS 8'h0c

// ==========================================================
// Reset values
`define TSS_RST_TXSEL 8'h10
`define TSS_RST_TESTSEL 8'h00
`define TSS_RST_DRVCTL 8'h00

// ==========================================================
// Source select fields
`define TSS_LM_HI 7
`define TSS_LM_LO 6
`define TSS_DRV_HI 5
`define TSS_DRV_LO 4
`define TSS_AUX_HI 3
`define TSS_AUX_LO 0

// Test selection fields
`define TSS_TBIT_HI 2
`define TSS_TBIT_LO 0
`define TSS_LMT_HI 5
`define TSS_LMT_LO 4

// Driver control bits
`define TSS_DRV1_EN 0
`define TSS_DRV2_EN 1
`define TSS_DRV1_INV_OFF 4
`define TSS_DRV2_INV_OFF 5
`define TSS_DRV1_INV_ON 6
`define TSS_DRV2_INV_ON 7

// AXI responses
`define TSS_RESP_OKAY 2'h0
`define TSS_RESP_DECERR 2'h3

`endif

// >>> tx_source_pkg.sv
// Types shared by the transmit source mux and its surroundings
package tx_source_pkg;

	// ==========================================================
	// Candidate signal sources, all in the aclk domain except ext_env
	typedef struct packed {
		logic coder_env;
		logic ext_env;
		logic tx_serial;
		logic rx_regen;
		logic rx_serial;
		logic demod_cmp;
		logic rx_carrier;
		logic tx_carrier;
		logic rx_unfilt_carrier;
		logic rx_unfilt_env;
	} tx_sources_t;

	// One driven pin: level and output enable
	typedef struct packed {
		logic o;
		logic oe;
	} pin_drive_t;

	typedef enum logic [1:0] {
		LM_TRISTATE,
		LM_CODER,
		LM_EXT_ENV,
		LM_TEST
	} lm_sel_t;

	typedef enum logic [1:0] {
		DRV_TRISTATE,
		DRV_CODER,
		DRV_EXT_ENV,
		DRV_HIGH
	} drv_sel_t;

endpackage : tx_source_pkg

// >>> tx_signal_source_select.sv
// Transmit source multiplexer with AXI4-Lite register slave
`timescale 1ns/1ps
`include "tx_source_defs.svh"

module tx_signal_source_select
	import tx_source_pkg::*;
#(
	parameter int TEST_SIGS = 4,
	parameter int TEST_BUS_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire tx_sources_t sources,
	input wire logic [TEST_SIGS-1:0] test_signals,
	input wire logic [TEST_BUS_W-1:0] test_bus,
	output pin_drive_t load_modulation_pin,
	output pin_drive_t antenna_driver_one,
	output pin_drive_t antenna_driver_two,
	output pin_drive_t aux_signal_output
);

	// ==========================================================
	// Parameter checks
	if (TEST_SIGS != 4 || TEST_BUS_W != 8) begin : g_bad_widths
		$error("test widths must match the 2-bit and 3-bit select fields");
	end

	// ==========================================================
	// Registers
	logic [7:0] transmit_source_select_ff;
	logic [7:0] test_selection_register_ff;
	logic [7:0] drv_ctl_ff;
	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [3:0] wstrb_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic do_write;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == `TSS_OFF_TXSEL) || (a == `TSS_OFF_TESTSEL) ||
			(a == `TSS_OFF_DRVCTL) || (a == `TSS_OFF_STATUS);
	endfunction : mapped

	assign do_write = !awready_ff && !wready_ff && !bvalid_ff;

	// ==========================================================
	// Write channels: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			bvalid_ff <= 1'b0;
			bresp_ff <= `TSS_RESP_OKAY;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h0;
			wstrb_ff <= 4'h0;
		end else begin
			if (s_axi_awvalid && awready_ff) begin
				awready_ff <= 1'b0;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_ff) begin
				wready_ff <= 1'b0;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (do_write) begin
				bvalid_ff <= 1'b1;
				bresp_ff <= mapped(awaddr_ff) ? `TSS_RESP_OKAY : `TSS_RESP_DECERR;
			end
			if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff <= 1'b1;
			end
		end
	end

	// Only byte lane 0 carries register bits; status is read-only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			transmit_source_select_ff <= `TSS_RST_TXSEL;
			test_selection_register_ff <= `TSS_RST_TESTSEL;
			drv_ctl_ff <= `TSS_RST_DRVCTL;
		end else if (do_write && wstrb_ff[0]) begin
			if (awaddr_ff == `TSS_OFF_TXSEL) begin
				transmit_source_select_ff <= wdata_ff[7:0];
			end else if (awaddr_ff == `TSS_OFF_TESTSEL) begin
				test_selection_register_ff <= wdata_ff[7:0];
			end else if (awaddr_ff == `TSS_OFF_DRVCTL) begin
				drv_ctl_ff <= wdata_ff[7:0];
			end
		end
	end

	// ==========================================================
	// Read channel: answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rresp_ff <= `TSS_RESP_OKAY;
		end else if (s_axi_arvalid && arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rresp_ff <= mapped(s_axi_araddr) ? `TSS_RESP_OKAY : `TSS_RESP_DECERR;
			if (s_axi_araddr == `TSS_OFF_TXSEL) begin
				rdata_ff <= {24'h0, transmit_source_select_ff};
			end else if (s_axi_araddr == `TSS_OFF_TESTSEL) begin
				rdata_ff <= {24'h0, test_selection_register_ff};
			end else if (s_axi_araddr == `TSS_OFF_DRVCTL) begin
				rdata_ff <= {24'h0, drv_ctl_ff};
			end else if (s_axi_araddr == `TSS_OFF_STATUS) begin
				rdata_ff <= {24'h0, aux_signal_output, antenna_driver_two,
					antenna_driver_one, load_modulation_pin};
			end else begin
				rdata_ff <= 32'h0;
			end
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	// ==========================================================
	// External envelope pin synchroniser
	logic env_s1_ff, env_s2_ff, env_s3_ff, ext_env_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			env_s1_ff <= 1'b0;
			env_s2_ff <= 1'b0;
			env_s3_ff <= 1'b0;
			ext_env_ff <= 1'b0;
		end else begin
			env_s1_ff <= sources.ext_env;
			env_s2_ff <= env_s1_ff;
			env_s3_ff <= env_s2_ff;
			// Accept a change only once two stages agree, filtering one-cycle spikes
			if (env_s2_ff == env_s3_ff)
				ext_env_ff <= env_s3_ff;
		end
	end

	// ==========================================================
	// Output selection
	lm_sel_t lm_sel;
	drv_sel_t drv_sel;
	logic [3:0] aux_sel;
	pin_drive_t nxt_lm, nxt_drv1, nxt_drv2, nxt_aux;
	logic drv_level, inv1, inv2;

	assign lm_sel = lm_sel_t'(transmit_source_select_ff[`TSS_LM_HI:`TSS_LM_LO]);
	assign drv_sel = drv_sel_t'(transmit_source_select_ff[`TSS_DRV_HI:`TSS_DRV_LO]);
	assign aux_sel = transmit_source_select_ff[`TSS_AUX_HI:`TSS_AUX_LO];

	// Field-on inversion applies while enabled, field-off inversion otherwise
	assign inv1 = drv_ctl_ff[`TSS_DRV1_EN] ? drv_ctl_ff[`TSS_DRV1_INV_ON] :
		drv_ctl_ff[`TSS_DRV1_INV_OFF];
	assign inv2 = drv_ctl_ff[`TSS_DRV2_EN] ? drv_ctl_ff[`TSS_DRV2_INV_ON] :
		drv_ctl_ff[`TSS_DRV2_INV_OFF];

	always_comb begin
		nxt_lm = '{o: 1'b0, oe: 1'b1};
		case (lm_sel)
			LM_TRISTATE: nxt_lm.oe = 1'b0;
			LM_CODER: nxt_lm.o = sources.coder_env;
			LM_EXT_ENV: nxt_lm.o = ext_env_ff;
			LM_TEST: nxt_lm.o = test_signals[test_selection_register_ff[`TSS_LMT_HI:`TSS_LMT_LO]];
			default: nxt_lm.oe = 1'b0;
		endcase
	end

	always_comb begin
		drv_level = 1'b0;
		case (drv_sel)
			DRV_TRISTATE: drv_level = 1'b0;
			DRV_CODER: drv_level = sources.coder_env;
			DRV_EXT_ENV: drv_level = ext_env_ff;
			DRV_HIGH: drv_level = 1'b1;
			default: drv_level = 1'b0;
		endcase
		nxt_drv1 = '{o: drv_level ^ inv1, oe: drv_sel != DRV_TRISTATE};
		nxt_drv2 = '{o: drv_level ^ inv2, oe: drv_sel != DRV_TRISTATE};
	end

	always_comb begin
		nxt_aux = '{o: 1'b0, oe: 1'b1};
		case (aux_sel)
			4'h0: nxt_aux.oe = 1'b0;
			4'h1: nxt_aux.o = 1'b0;
			4'h2: nxt_aux.o = 1'b1;
			4'h3: nxt_aux.o = test_bus[test_selection_register_ff[`TSS_TBIT_HI:`TSS_TBIT_LO]];
			4'h4: nxt_aux.o = sources.coder_env;
			4'h5: nxt_aux.o = sources.tx_serial;
			4'h6: nxt_aux.o = sources.rx_regen;
			4'h7: nxt_aux.o = sources.rx_serial;
			4'h8: nxt_aux.o = sources.rx_serial;
			4'h9: nxt_aux.o = sources.tx_serial;
			4'ha: nxt_aux.o = sources.demod_cmp;
			4'hb: nxt_aux.oe = 1'b0;
			4'hc: nxt_aux.o = sources.rx_carrier;
			4'hd: nxt_aux.o = sources.tx_carrier;
			4'he: nxt_aux.o = sources.rx_unfilt_carrier;
			default: nxt_aux.o = sources.rx_unfilt_env;
		endcase
	end

	// Registered pins: no combinational path glitches during a select change
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			load_modulation_pin <= '0;
			antenna_driver_one <= '0;
			antenna_driver_two <= '0;
			aux_signal_output <= '0;
		end else begin
			load_modulation_pin <= nxt_lm;
			antenna_driver_one <= nxt_drv1;
			antenna_driver_two <= nxt_drv2;
			aux_signal_output <= nxt_aux;
		end
	end

	// ==========================================================
	// Checks
	// Attempts launched on the release edge would judge pins still held in reset
	logic live_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			live_ff <= 1'b0;
		end else begin
			live_ff <= 1'b1;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !live_ff);

	chk_lm_tristate: assert property (
		transmit_source_select_ff[7:6] == 2'b00 |=> !load_modulation_pin.oe)
		else $error("load modulation pin not tristate");
	chk_lm_coder: assert property (
		transmit_source_select_ff[7:6] == 2'b01 |=>
		load_modulation_pin.oe && load_modulation_pin.o == $past(sources.coder_env))
		else $error("load modulation pin does not follow coder");
	chk_lm_test: assert property (
		transmit_source_select_ff[7:6] == 2'b11 |=>
		load_modulation_pin.o == $past(test_signals[test_selection_register_ff[5:4]]))
		else $error("load modulation test signal wrong");
	chk_drv_high: assert property (
		transmit_source_select_ff[5:4] == 2'b11 && drv_ctl_ff[0] |=>
		antenna_driver_one.o == !$past(drv_ctl_ff[6]))
		else $error("driver one high level ignores field-on inversion");
	chk_drv_off_inv: assert property (
		transmit_source_select_ff[5:4] == 2'b01 && !drv_ctl_ff[1] |=>
		antenna_driver_two.o == ($past(sources.coder_env) ^ $past(drv_ctl_ff[5])))
		else $error("driver two field-off inversion wrong");
	chk_drv_tristate: assert property (
		transmit_source_select_ff[5:4] == 2'b00 |=>
		!antenna_driver_one.oe && !antenna_driver_two.oe)
		else $error("drivers not tristate");
	chk_aux_testbus: assert property (
		transmit_source_select_ff[3:0] == 4'h3 |=>
		aux_signal_output.o == $past(test_bus[test_selection_register_ff[2:0]]))
		else $error("aux test bus bit wrong");
	chk_aux_rx_regen: assert property (
		transmit_source_select_ff[3:0] == 4'h6 |=> aux_signal_output.o == $past(sources.rx_regen))
		else $error("aux receiver output wrong");
	chk_aux_reserved: assert property (
		transmit_source_select_ff[3:0] == 4'hb |=> !aux_signal_output.oe)
		else $error("reserved aux code not tristate");
	chk_write_takes: assert property (
		do_write && wstrb_ff[0] && awaddr_ff == 8'h00 |=> ##1
		aux_signal_output.oe == ($past(wdata_ff[3:0], 2) != 4'h0 && $past(wdata_ff[3:0], 2) != 4'hb))
		else $error("selection did not take effect after write");

	cov_aux_rx: cover property (transmit_source_select_ff[3:0] == 4'h8 ##1 aux_signal_output.oe);
	cov_drv_high: cover property (transmit_source_select_ff[5:4] == 2'b11 ##1 antenna_driver_one.oe);
	cov_write_read: cover property (s_axi_bvalid && s_axi_bready ##[1:20] s_axi_rvalid);

endmodule : tx_signal_source_select

// >>> tx_far_side_model.sv
// Far-side model: candidate source lines and receive activity
`timescale 1ns/1ps

module tx_far_side_model
	import tx_source_pkg::*;
(
	input wire logic aclk,
	input wire logic receiving,
	input wire tx_sources_t src_req,
	input wire logic [3:0] tsig_req,
	input wire logic [7:0] tbus_req,
	output tx_sources_t sources,
	output logic [3:0] test_signals,
	output logic [7:0] test_bus
);
	// ==========================================================
	// Source lines
	// rx_regen, rx_serial and rx_carrier stay low until the unit is put in receive mode
	always_ff @(posedge aclk) begin
		sources <= src_req;
		if (!receiving) begin
			sources.rx_regen <= 1'b0;
			sources.rx_serial <= 1'b0;
			sources.rx_carrier <= 1'b0;
		end
	end

	// Only bit-stable coding is modelled, no Manchester collisions
	always_ff @(posedge aclk) begin
		test_signals <= tsig_req;
		test_bus <= tbus_req;
	end
endmodule : tx_far_side_model

// >>> tx_signal_source_select_tb_top.sv
// Self-checking bench for the transmit source multiplexer
`timescale 1ns/1ps
`include "tx_source_defs.svh"

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("BAD %s exp %0h got %0h", nm, e, g); end end

module tx_signal_source_select_tb_top
	import tx_source_pkg::*;
;
	logic aclk;
	logic aresetn;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, receiving;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	tx_sources_t sources, src_req;
	logic [3:0] test_signals, tsig_req;
	logic [7:0] test_bus, tbus_req;
	pin_drive_t lm_pin, drv_one, drv_two, aux_pin;
	int error_cnt;
	int checks;

	tx_signal_source_select dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .sources, .test_signals, .test_bus,
		.load_modulation_pin(lm_pin), .antenna_driver_one(drv_one),
		.antenna_driver_two(drv_two), .aux_signal_output(aux_pin));

	tx_far_side_model far_side (.aclk, .receiving, .src_req, .tsig_req, .tbus_req, .sources,
		.test_signals, .test_bus);

	// ==========================================================
	// Helpers
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run

	// Tristate pins carry no meaningful level, so only oe is compared
	task automatic pchk(input string nm, input pin_drive_t p, input logic [1:0] e);
		`CHK(nm, e[1], p.oe)
		if (e[1]) `CHK(nm, e[0], p.o)
	endtask : pchk

	// Eight cycles cover the far-side flop, the pin synchroniser and the output flop
	task automatic drive_src(input tx_sources_t s, input logic [3:0] ts, input logic [7:0] tb);
		@(posedge aclk);
		src_req <= s;
		tsig_req <= ts;
		tbus_req <= tb;
		repeat (8) @(posedge aclk);
	endtask : drive_src

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		int n;
		logic aw;
		logic w;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw = 0;
		w = 0;
		n = 0;
		while (!(aw && w) && n < 50) begin
			@(posedge aclk);
			n++;
			if (!aw && s_axi_awready) begin
				aw = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready) begin
				w = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!s_axi_bvalid && n < 50) begin
			@(posedge aclk);
			n++;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 50) `CHK("write handshake", 1'b1, 1'b0)
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!s_axi_arready && n < 50);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid && n < 50) begin
			@(posedge aclk);
			n++;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 50) `CHK("read handshake", 1'b1, 1'b0)
	endtask : axi_read

	function automatic logic [1:0] exp_aux(input int c, input tx_sources_t s);
		case (c)
			1: return 2'b10;
			2: return 2'b11;
			4: return {1'b1, s.coder_env};
			5, 9: return {1'b1, s.tx_serial};
			6: return {1'b1, s.rx_regen};
			7, 8: return {1'b1, s.rx_serial};
			10: return {1'b1, s.demod_cmp};
			12: return {1'b1, s.rx_carrier};
			13: return {1'b1, s.tx_carrier};
			14: return {1'b1, s.rx_unfilt_carrier};
			15: return {1'b1, s.rx_unfilt_env};
			default: return 2'b00;
		endcase
	endfunction : exp_aux

	// ==========================================================
	// Scenarios
	task automatic test_reset();
		logic [31:0] d;
		logic [1:0] r;
		repeat (3) @(posedge aclk);
		pchk("lm", lm_pin, 2'b00);
		pchk("drv1", drv_one, 2'b11);
		pchk("aux", aux_pin, 2'b00);
		axi_read(`TSS_OFF_TXSEL, d, r);
		`CHK("txsel", {24'h0, `TSS_RST_TXSEL}, d)
		axi_read(8'h10, d, r);
		`CHK("unmapped resp", `TSS_RESP_DECERR, r)
		axi_write(`TSS_OFF_TXSEL, 32'hffffff02, 4'hf, r);
		@(posedge aclk);
		#1;
		pchk("aux", aux_pin, 2'b11);
		pchk("drv2", drv_two, 2'b00);
		axi_read(`TSS_OFF_STATUS, d, r);
		`CHK("status", 32'hc0, d)
		axi_write(`TSS_OFF_TXSEL, 32'h30, 4'h0, r);
		axi_write(8'h10, 32'h30, 4'hf, r);
		`CHK("unmapped wr", `TSS_RESP_DECERR, r)
		axi_read(`TSS_OFF_TXSEL, d, r);
		`CHK("txsel", 32'h02, d)
		$display("test_reset done");
	endtask : test_reset

	task automatic test_lm();
		logic [1:0] r;
		tx_sources_t s;
		for (int c = 0; c < 3; c++) begin
			axi_write(`TSS_OFF_TXSEL, 32'(c << 6), 4'h1, r);
			for (int k = 0; k < 10; k++) begin
				s = tx_sources_t'(10'h1 << k);
				drive_src(s, 4'h0, 8'h0);
				pchk("lm", lm_pin, c == 0 ? 2'b00 : {1'b1, c == 1 ? s.coder_env : s.ext_env});
			end
		end
		axi_write(`TSS_OFF_TXSEL, 32'hc0, 4'h1, r);
		for (int k = 0; k < 4; k++) begin
			axi_write(`TSS_OFF_TESTSEL, 32'(k << 4), 4'h1, r);
			drive_src('0, 4'h1 << k, 8'h0);
			pchk("lm test", lm_pin, 2'b11);
			drive_src('0, ~(4'h1 << k), 8'h0);
			pchk("lm test", lm_pin, 2'b10);
		end
		$display("test_lm done");
	endtask : test_lm

	task automatic test_drv();
		logic [1:0] r;
		logic [7:0] ctl [8] = '{8'h00, 8'h41, 8'h40, 8'h10, 8'h82, 8'h20, 8'hf3, 8'hf0};
		logic lvl;
		logic [31:0] d;
		for (int c = 1; c < 4; c++) begin
			axi_write(`TSS_OFF_TXSEL, 32'(c << 4), 4'h1, r);
			foreach (ctl[i]) begin
				axi_write(`TSS_OFF_DRVCTL, {24'h0, ctl[i]}, 4'h1, r);
				for (int v = 0; v < 2; v++) begin
					lvl = (c == 3) ? 1'b1 : v[0];
					drive_src(v ? 10'h300 : 10'h0, 4'h0, 8'h0);
					pchk("drv1", drv_one, {1'b1, lvl ^ (ctl[i][0] ? ctl[i][6] : ctl[i][4])});
					pchk("drv2", drv_two, {1'b1, lvl ^ (ctl[i][1] ? ctl[i][7] : ctl[i][5])});
				end
			end
		end
		axi_read(`TSS_OFF_DRVCTL, d, r);
		`CHK("drvctl", 32'hf0, d)
		$display("test_drv done");
	endtask : test_drv

	task automatic test_aux();
		logic [1:0] r;
		tx_sources_t s;
		logic [1:0] e;
		logic [31:0] d;
		for (int c = 0; c < 16; c++) begin
			if (c == 3) continue;
			axi_write(`TSS_OFF_TXSEL, 32'(c), 4'h1, r);
			for (int k = 0; k < 10; k++) begin
				s = tx_sources_t'(10'h1 << k);
				drive_src(s, 4'h0, 8'h0);
				e = exp_aux(c, s);
				pchk("aux", aux_pin, e);
			end
		end
		axi_write(`TSS_OFF_TXSEL, 32'h3, 4'h1, r);
		for (int k = 0; k < 8; k++) begin
			axi_write(`TSS_OFF_TESTSEL, 32'(k), 4'h1, r);
			drive_src('0, 4'h0, 8'h1 << k);
			pchk("aux bus", aux_pin, 2'b11);
			drive_src('0, 4'h0, ~(8'h1 << k));
			pchk("aux bus", aux_pin, 2'b10);
		end
		axi_read(`TSS_OFF_TESTSEL, d, r);
		`CHK("testsel", 32'h07, d)
		$display("test_aux done");
	endtask : test_aux

	// Reset in mid-run must restore the reset selection and clear the earlier source select and driver control writes
	task automatic test_midrun_reset();
		logic [31:0] d;
		logic [1:0] r;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		pchk("aux", aux_pin, 2'b00);
		pchk("drv2", drv_two, {1'b1, src_req.coder_env});
		pchk("lm", lm_pin, 2'b00);
		axi_read(`TSS_OFF_TXSEL, d, r);
		`CHK("txsel", {24'h0, `TSS_RST_TXSEL}, d)
		$display("test_midrun_reset done");
	endtask : test_midrun_reset

	// ==========================================================
	// Run control
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	initial begin
		repeat (30000) @(posedge aclk);
		`CHK("watchdog", 1'b1, 1'b0)
		complete_run();
	end

	initial begin
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		src_req = 10'h200;
		tsig_req = 4'h0;
		tbus_req = 8'h0;
		receiving = 1'b0;
		error_cnt = 0;
		checks = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		test_reset();
		test_lm();
		test_drv();
		receiving <= 1'b1;
		test_aux();
		test_midrun_reset();
		complete_run();
	end
endmodule : tx_signal_source_select_tb_top
